// File: ptm_pkg.sv
// Package with register map, field positions and encodings of the periodic timer.
package ptm_pkg;
   localparam int CNT_W = 10;
   // Register byte addresses, one aligned word each.
   localparam logic [11:0] ADDR_CTRL0 = 12'h000;
   localparam logic [11:0] ADDR_CTRL1 = 12'h004;
   localparam logic [11:0] ADDR_CNT_L = 12'h008;
   localparam logic [11:0] ADDR_CNT_H = 12'h00c;
   localparam logic [11:0] ADDR_CMPA_L = 12'h010;
   localparam logic [11:0] ADDR_CMPA_H = 12'h014;
   localparam logic [11:0] ADDR_PER_L = 12'h018;
   localparam logic [11:0] ADDR_PER_H = 12'h01c;
   localparam logic [11:0] ADDR_STATUS = 12'h020;
   localparam logic [11:0] ADDR_PINSEL = 12'h024;
   // Control 0 fields.
   localparam int C0_PAUSE = 7;
   localparam int C0_CKS_LSB = 4;
   localparam int C0_ON = 3;
   // Control 1 fields.
   localparam int C1_MODE_LSB = 6;
   localparam int C1_PINF_LSB = 4;
   localparam int C1_OLEVEL = 3;
   localparam int C1_INVERT = 2;
   localparam int C1_CAPSRC = 1;
   localparam int C1_CLRSRC = 0;
   // Pin select register fields.
   localparam int PS_OUT = 0;
   localparam int PS_OUTB = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [9:0] CNT_MAX = 10'h3ff;
   // Prescaler ratios.
   localparam int DIV_SYS4 = 4;
   localparam int DIV_H16 = 16;
   localparam int DIV_H64 = 64;
   localparam int DIV_SUB = 256;
   typedef enum logic [1:0] {
      MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER
   } ptm_mode_e;
endpackage : ptm_pkg

// File: ptm_prescaler.sv
// Counter clock selector producing a one-cycle count tick.
module ptm_prescaler #(
   parameter int DIV_SUB_P = ptm_pkg::DIV_SUB
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   input  wire logic       ext_clock_pin,
   output logic            tick
);
   logic [7:0] div_q;
   logic       ext_q;
   wire        ext_rise = ext_clock_pin & ~ext_q;
   wire        ext_fall = ~ext_clock_pin & ext_q;

   function automatic logic div_hit(input logic [7:0] c, input int n);
      div_hit = (c[7:0] & 8'(n - 1)) == 8'h00;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
         ext_q <= 1'b0;
      end else begin
         div_q <= div_q + 8'h01;
         ext_q <= ext_clock_pin;
      end
   end

   // The high clock and sub clock are modelled as fixed divisions of pclk.
   always_comb begin
      case (sel)
         3'h0: tick = div_hit(div_q, ptm_pkg::DIV_SYS4); // see RL7
         3'h1: tick = 1'b1;
         3'h2: tick = div_hit(div_q, ptm_pkg::DIV_H16);
         3'h3: tick = div_hit(div_q, ptm_pkg::DIV_H64);
         3'h4, 3'h5: tick = div_hit(div_q, DIV_SUB_P);
         3'h6: tick = ext_rise;
         3'h7: tick = ext_fall;
         default: tick = 1'b0;
      endcase
      tick = tick & run;
   end
endmodule : ptm_prescaler

// File: ptm_capture_edge.sv
// Edge detector for the capture trigger source.
module ptm_capture_edge (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       src_sel,
   input  wire logic       capture_input_pin,
   input  wire logic       ext_clock_pin,
   input  wire logic [1:0] edge_sel,
   output logic            hit
);
   logic prev_q;
   wire  src = src_sel ? ext_clock_pin : capture_input_pin; // see RL23
   wire  rise = src & ~prev_q;
   wire  fall = ~src & prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prev_q <= 1'b0;
      else prev_q <= src;
   end

   always_comb begin
      case (edge_sel)
         2'h0: hit = rise; // see RL13
         2'h1: hit = fall;
         2'h2: hit = rise | fall;
         default: hit = 1'b0;
      endcase
   end
endmodule : ptm_capture_edge

// File: ptm_timer.sv
// Periodic timer top: APB registers, counter, comparators, output and capture.
//
// Contract
// RL1: 10-bit up counter on selected clock.
// RL2: Comparators A and P check every count.
// RL3: Counter-on rising edge zeroes the counter.
// RL4: Auto clear on overflow or match, event.
// RL5: Counter-on low stops and holds value.
// RL6: Pause bit freezes counter, resume later.
// RL7: Three-bit clock source selection.
// RL8: Two-bit operating mode selection.
// RL9: Software stops timer before mode change.
// RL10: Software disables pin in timer mode.
// RL11: Compare mode pin action on match.
// RL12: PWM mode pin function selection.
// RL13: Capture mode edge selection.
// RL14: Inverted pin mirrors main output.
// RL15: Counter-on rise restores initial output level.
// RL16: Pin select bit routes pin to timer.
// RL17: Low write buffered until high write.
// RL18: High read copies low byte to buffer.
// RL19: Software writes low first, reads high first.
// RL20: Counter read-only, compares read-write.
// RL21: Clear source picks A or P/overflow.
// RL22: Overflow at 3ff wraps to zero.
// RL23: Capture source pin or clock pin.
// RL24: Output level sets initial or polarity.
// RL25: Capture stores counter into compare A.
//
// Design decisions made here: the APB slave port and the address map.
module ptm_timer #(
   parameter int DIV_SUB_P = ptm_pkg::DIV_SUB
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clock_pin,
   input  wire logic        capture_input_pin,
   output logic             timer_output_pin,
   output logic             timer_output_pin_oe,
   output logic             timer_output_inverted_pin,
   output logic             timer_output_inverted_pin_oe,
   output logic             match_a_event,
   output logic             match_p_event
);
   localparam int W = ptm_pkg::CNT_W;

   logic [7:0]   ctrl0_q, ctrl1_q, buf_q;
   logic [1:0]   pinsel_q;
   logic [W-1:0] cnt_q, cmpa_q, per_q;
   logic         on_q, out_q, pulse_q, flag_a_q, flag_p_q;

   // Register decode.
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire rd       = acc & ~pwrite;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire hit_c0   = paddr == ptm_pkg::ADDR_CTRL0;
   wire hit_c1   = paddr == ptm_pkg::ADDR_CTRL1;
   wire hit_dl   = paddr == ptm_pkg::ADDR_CNT_L;
   wire hit_dh   = paddr == ptm_pkg::ADDR_CNT_H;
   wire hit_al   = paddr == ptm_pkg::ADDR_CMPA_L;
   wire hit_ah   = paddr == ptm_pkg::ADDR_CMPA_H;
   wire hit_pl   = paddr == ptm_pkg::ADDR_PER_L;
   wire hit_ph   = paddr == ptm_pkg::ADDR_PER_H;
   wire hit_st   = paddr == ptm_pkg::ADDR_STATUS;
   wire hit_ps   = paddr == ptm_pkg::ADDR_PINSEL;
   wire mapped   = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al | hit_ah | hit_pl | hit_ph
                   | hit_st | hit_ps;

   // Control fields.
   wire       pause   = ctrl0_q[ptm_pkg::C0_PAUSE];
   wire [2:0] cks     = ctrl0_q[ptm_pkg::C0_CKS_LSB +: 3];
   wire       on      = ctrl0_q[ptm_pkg::C0_ON];
   wire [1:0] pinf    = ctrl1_q[ptm_pkg::C1_PINF_LSB +: 2];
   wire       olevel  = ctrl1_q[ptm_pkg::C1_OLEVEL];
   wire       invert  = ctrl1_q[ptm_pkg::C1_INVERT];
   wire       capsrc  = ctrl1_q[ptm_pkg::C1_CAPSRC];
   wire       clrsrc  = ctrl1_q[ptm_pkg::C1_CLRSRC];
   ptm_pkg::ptm_mode_e mode;
   assign mode = ptm_pkg::ptm_mode_e'(ctrl1_q[ptm_pkg::C1_MODE_LSB +: 2]); // see RL8

   wire on_rise = on & ~on_q; // see RL3

   logic tick;
   ptm_prescaler #(
      .DIV_SUB_P (DIV_SUB_P)
   ) u_presc (
      .pclk          (pclk),
      .presetn       (presetn),
      .run           (on & ~pause), // see RL5, RL6
      .sel           (cks),
      .ext_clock_pin (ext_clock_pin),
      .tick          (tick)
   );

   logic cap_hit_raw;
   ptm_capture_edge u_cap (
      .pclk              (pclk),
      .presetn           (presetn),
      .src_sel           (capsrc),
      .capture_input_pin (capture_input_pin),
      .ext_clock_pin     (ext_clock_pin),
      .edge_sel          (pinf),
      .hit               (cap_hit_raw)
   );
   wire cap_hit = cap_hit_raw & on & (mode == ptm_pkg::MODE_CAPTURE);

   // Comparators look at the counter value on each count tick.
   wire at_a     = cnt_q == cmpa_q; // see RL2
   wire at_p     = cnt_q == per_q;
   wire at_max   = cnt_q == ptm_pkg::CNT_MAX; // see RL22
   wire match_a  = tick & at_a;
   wire per_zero = per_q == '0;
   wire match_p  = tick & (per_zero ? at_max : at_p);
   // Compare and timer modes honour the clear source; PWM and capture run on P.
   wire use_a    = clrsrc & ((mode == ptm_pkg::MODE_COMPARE) | (mode == ptm_pkg::MODE_TIMER));
   wire clr_cnt  = use_a ? (match_a | (tick & at_max)) : match_p; // see RL21
   wire ev_a     = (match_a & ~(cmpa_q == '0 && use_a)) | cap_hit; // see RL4
   wire ev_p     = match_p & ~use_a;

   // Counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         on_q  <= 1'b0;
      end else begin
         on_q <= on;
         if (on_rise) cnt_q <= '0; // see RL3
         else if (clr_cnt) cnt_q <= '0; // see RL4
         else if (tick) cnt_q <= cnt_q + 1'b1; // see RL1
      end
   end

   // Output waveform logic before polarity.
   logic out_d;
   always_comb begin
      out_d = out_q;
      if (on_rise) begin
         out_d = olevel; // see RL15
      end else begin
         case (mode)
            ptm_pkg::MODE_COMPARE: begin
               if (ev_a) begin
                  case (pinf) // see RL11
                     2'h1: out_d = 1'b0;
                     2'h2: out_d = 1'b1;
                     2'h3: out_d = ~out_q;
                     default: out_d = out_q;
                  endcase
               end
            end
            ptm_pkg::MODE_PWM: begin
               // Active until A matches, inactive until the period restarts.
               if (pinf == 2'h2 && match_p) out_d = olevel;
               else if (pinf[1] && match_a) out_d = ~olevel;
            end
            default: out_d = out_q;
         endcase
      end
   end

   // Level for the pin before polarity, with the PWM forced states applied.
   logic wave;
   always_comb begin
      wave = out_q;
      if (mode == ptm_pkg::MODE_PWM) begin
         case (pinf) // see RL12, RL24
            2'h0: wave = ~olevel;
            2'h1: wave = olevel;
            2'h3: wave = pulse_q ? out_q : ~olevel;
            default: wave = out_q;
         endcase
      end
   end

   // Single pulse is armed by the counter-on rise and ends at the A match.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q   <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         out_q <= out_d;
         if (on_rise) pulse_q <= 1'b1;
         else if (match_a) pulse_q <= 1'b0;
      end
   end

   wire pin_level = wave ^ invert;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_output_pin          <= 1'b0;
         timer_output_inverted_pin <= 1'b1;
      end else begin
         timer_output_pin          <= pin_level;
         timer_output_inverted_pin <= ~pin_level; // see RL14
      end
   end
   assign timer_output_pin_oe          = pinsel_q[ptm_pkg::PS_OUT];  // see RL16
   assign timer_output_inverted_pin_oe = pinsel_q[ptm_pkg::PS_OUTB];

   // Register writes, shared low-byte buffer and capture.
   wire [7:0] wbyte     = pwdata[7:0];
   // The low byte is copied at the edge that latches the high byte, so a count tick
   // between the two phases cannot tear the pair.
   wire       rd_high   = setup_rd & (hit_dh | hit_ah | hit_ph);
   wire [7:0] high_low  = hit_dh ? cnt_q[7:0] : hit_ah ? cmpa_q[7:0] : per_q[7:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_q  <= ptm_pkg::CTRL_RESET;
         ctrl1_q  <= ptm_pkg::CTRL_RESET;
         pinsel_q <= 2'h0;
         buf_q    <= 8'h00;
         cmpa_q   <= '0;
         per_q    <= '0;
      end else begin
         if (wr & hit_c0) ctrl0_q <= {wbyte[7:3], 3'h0};
         if (wr & hit_c1) ctrl1_q <= wbyte;
         if (wr & hit_ps) pinsel_q <= wbyte[1:0];
         if (wr & (hit_al | hit_pl)) buf_q <= wbyte; // see RL17
         if (rd_high) buf_q <= high_low; // see RL18
         if (cap_hit) cmpa_q <= cnt_q; // see RL25
         else if (wr & hit_ah) cmpa_q <= {wbyte[1:0], buf_q}; // see RL17, RL20
         if (wr & hit_ph) per_q <= {wbyte[1:0], buf_q};
      end
   end

   // Sticky status of the match events, cleared by writing ones.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else begin
         flag_a_q <= ev_a | (flag_a_q & ~(wr & hit_st & pwdata[0]));
         flag_p_q <= ev_p | (flag_p_q & ~(wr & hit_st & pwdata[1]));
      end
   end
   assign match_a_event = ev_a;
   assign match_p_event = ev_p;

   // Read mux; low-byte reads of the pairs return the buffer.
   logic [7:0] rbyte;
   always_comb begin
      rbyte = 8'h00;
      if (hit_c0) rbyte = ctrl0_q;
      else if (hit_c1) rbyte = ctrl1_q;
      else if (hit_dl | hit_al | hit_pl) rbyte = buf_q;
      else if (hit_dh) rbyte = {6'h00, cnt_q[9:8]};
      else if (hit_ah) rbyte = {6'h00, cmpa_q[9:8]};
      else if (hit_ph) rbyte = {6'h00, per_q[9:8]};
      else if (hit_st) rbyte = {6'h00, flag_p_q, flag_a_q};
      else if (hit_ps) rbyte = {6'h00, pinsel_q};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (setup_rd) prdata <= {24'h00_0000, rbyte};
   end
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // Assertions.
   sequence s_on_rise;
      on & !$past(on);
   endsequence

   a_on_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RL3
      s_on_rise |=> cnt_q == '0) else $error("counter not cleared by enable");
   a_off_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
      !on && !$past(on) |=> $stable(cnt_q)) else $error("counter moved while off");
   a_pause_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
      pause && !on_rise |=> $stable(cnt_q)) else $error("counter moved while paused");
   a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
      tick && !clr_cnt && !on_rise |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("counter did not advance by one");
   a_wrap_max: assert property (@(posedge pclk) disable iff (!presetn) // see RL22
      tick && at_max && !on_rise |=> cnt_q == '0) else $error("counter did not wrap");
   a_inv_pin: assert property (@(posedge pclk) disable iff (!presetn) // see RL14
      timer_output_inverted_pin == ~timer_output_pin) else $error("inverted pin mismatch");
   a_init_level: assert property (@(posedge pclk) disable iff (!presetn) // see RL15
      (s_on_rise and (mode == ptm_pkg::MODE_COMPARE)) |=>
      ##1 timer_output_pin == $past(olevel ^ invert, 2))
      else $error("output not restored to initial level");
   a_buf_write: assert property (@(posedge pclk) disable iff (!presetn) // see RL17
      wr && hit_ph |=> per_q == {$past(pwdata[1:0]), $past(buf_q)})
      else $error("period pair load wrong");
   a_hi_read: assert property (@(posedge pclk) disable iff (!presetn) // see RL18
      setup_rd && hit_ah |=> buf_q == $past(cmpa_q[7:0]))
      else $error("buffer not loaded on high read");
   a_cap_store: assert property (@(posedge pclk) disable iff (!presetn) // see RL25
      cap_hit |=> cmpa_q == $past(cnt_q)) else $error("capture value not stored");

   // After a period clear the counter is zero, so a second period event cannot follow.
   a_p_event_once: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
      ev_p |=> !ev_p)
      else $error("period event longer than one cycle");
   a_clear_on_p: assert property (@(posedge pclk) disable iff (!presetn) // see RL21
      match_p && !use_a |=> cnt_q == '0)
      else $error("period match did not clear");
   a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL21
      match_a && use_a |=> cnt_q == '0)
      else $error("compare A match did not clear");
   a_count_readonly: assert property (@(posedge pclk) disable iff (!presetn) // see RL20
      wr && (hit_dl || hit_dh) && !tick && !on_rise |=> $stable(cnt_q))
      else $error("counter changed by a write");
   a_oe_write: assert property (@(posedge pclk) disable iff (!presetn) // see RL16
      wr && hit_ps |=> timer_output_pin_oe == $past(pwdata[ptm_pkg::PS_OUT]))
      else $error("pin select not applied");
   a_cmp_low: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
      mode == ptm_pkg::MODE_COMPARE && pinf == 2'h1 && ev_a && !on_rise |=> !out_q)
      else $error("match did not drive low");
   a_cmp_high: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
      mode == ptm_pkg::MODE_COMPARE && pinf == 2'h2 && ev_a && !on_rise |=> out_q)
      else $error("match did not drive high");
   a_cmp_toggle: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
      mode == ptm_pkg::MODE_COMPARE && pinf == 2'h3 && ev_a && !on_rise |=> out_q != $past(out_q))
      else $error("match did not toggle");
   a_force_off: assert property (@(posedge pclk) disable iff (!presetn) // see RL12
      mode == ptm_pkg::MODE_PWM && pinf == 2'h0 |=> timer_output_pin == $past(~olevel ^ invert))
      else $error("forced inactive level wrong");
   a_pwm_start: assert property (@(posedge pclk) disable iff (!presetn) // see RL12, RL24
      mode == ptm_pkg::MODE_PWM && pinf == 2'h2 && match_p && !on_rise |=> out_q == $past(olevel))
      else $error("period start not active");
   a_pwm_stop: assert property (@(posedge pclk) disable iff (!presetn) // see RL12, RL24
      mode == ptm_pkg::MODE_PWM && pinf == 2'h2 && match_a && !match_p && !on_rise
      |=> out_q == !$past(olevel)) else $error("duty end not inactive");

   // A single pulse is armed by the counter-on rise and ends at the next A match.
   sequence s_pulse_arm;
      on_rise && mode == ptm_pkg::MODE_PWM && pinf == 2'h3;
   endsequence
   a_pulse_arm: assert property (@(posedge pclk) disable iff (!presetn) // see RL12, RL15
      s_pulse_arm |=> pulse_q && out_q == $past(olevel))
      else $error("single pulse not armed");
   a_pulse_end: assert property (@(posedge pclk) disable iff (!presetn) // see RL12
      pulse_q && match_a && !on_rise |=> !pulse_q)
      else $error("single pulse not ended");

   sequence s_flag_clear;
      wr && hit_st && pwdata[0];
   endsequence
   a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
      ev_a |=> flag_a_q)
      else $error("A flag not set by event");
   a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
      (s_flag_clear and !ev_a) |=> !flag_a_q)
      else $error("A flag not cleared");
   a_capture_off: assert property (@(posedge pclk) disable iff (!presetn) // see RL13
      pinf == 2'h3 |-> !cap_hit_raw)
      else $error("capture while disabled");
endmodule : ptm_timer

// File: ptm_pin_model.sv
// Far-side pin model: external count clock and capture input.
module ptm_pin_model (
   input  wire logic pclk,
   input  wire logic ext_run,
   output logic      ext_clock_pin,
   output logic      capture_input_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] div_q   = 2'h0;
   logic       pulse_q = 1'b0;
   initial ext_clock_pin = 1'b0;
   initial capture_input_pin = 1'b0;
   // The free clock has a period of eight cycles and rests low between runs.
   // A stray edge would otherwise reach the counter or the capture logic.
   always @(posedge pclk) begin
      div_q <= div_q + 2'h1;
      if (!ext_run)
         ext_clock_pin <= pulse_q;
      else if (div_q == 2'h3)
         ext_clock_pin <= ~ext_clock_pin;
   end
   task automatic set_capture(input logic v);
      @(posedge pclk);
      capture_input_pin <= v;
   endtask
   task automatic pulse_ext();
      @(posedge pclk);
      pulse_q <= 1'b1;
      repeat (3) @(posedge pclk);
      pulse_q <= 1'b0;
   endtask
endmodule // ptm_pin_model

// File: periodic_timer_module_tb_top.sv
// Self-checking bench for the periodic timer: registers, counting, pins and capture.
module periodic_timer_module_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SUBD = 4;
   localparam logic [3:0] MEXP = 4'b0101;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        ext_run = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rv;
   logic        pready, pslverr, re, ext_clock_pin, capture_input_pin;
   logic        out, out_oe, outb, outb_oe, ev_a, ev_p;
   logic [9:0]  v1, v2;
   logic [7:0]  pm [3] = '{8'h88, 8'h98, 8'h8c};
   logic [2:0]  pe = 3'b110;
   int          fails = 0;
   int          compares = 0;
   int          a_cnt = 0;
   int          n, hi;
   int          dv [8] = '{ptm_pkg::DIV_SYS4, 1, ptm_pkg::DIV_H16, ptm_pkg::DIV_H64,
                           SUBD, SUBD, 8, 8};

   ptm_timer #(.DIV_SUB_P(SUBD)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
      .timer_output_pin(out), .timer_output_pin_oe(out_oe),
      .timer_output_inverted_pin(outb), .timer_output_inverted_pin_oe(outb_oe),
      .match_a_event(ev_a), .match_p_event(ev_p));
   ptm_pin_model u_pins (.pclk(pclk), .ext_run(ext_run), .ext_clock_pin(ext_clock_pin),
      .capture_input_pin(capture_input_pin));

   always #2 pclk = ~pclk;
   always @(negedge pclk) if (ev_a === 1'b1) a_cnt++;

   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 8'h00);
   endtask
   // Pairs are always written low first and read high first.
   task automatic wr10(input logic [11:0] ah, input logic [9:0] v);
      wr(ah - 12'h004, v[7:0]);
      wr(ah, {6'h00, v[9:8]});
   endtask
   task automatic rd10(input logic [11:0] ah, output logic [9:0] v);
      logic [1:0] h;
      rd(ah);
      h = rv[1:0];
      rd(ah - 12'h004);
      v = {h, rv[7:0]};
   endtask
   // The mode is only changed while the timer is switched off.
   task automatic set_mode(input logic [7:0] c1);
      wr(ptm_pkg::ADDR_CTRL0, 8'h00);
      wr(ptm_pkg::ADDR_CTRL1, c1);
   endtask
   task automatic on(input logic [2:0] s);
      wr(ptm_pkg::ADDR_CTRL0, {1'b0, s, 4'h8});
   endtask
   // The first event may follow a partial period, so the span to the second one counts.
   task automatic gap(input bit p);
      n = 0;
      @(negedge pclk);
      while ((p ? ev_p : ev_a) !== 1'b1) @(negedge pclk);
      do begin
         @(negedge pclk);
         n++;
      end while ((p ? ev_p : ev_a) !== 1'b1);
   endtask
   task automatic complete_run();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #300000;
      fails++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(ptm_pkg::ADDR_CTRL0);
      check("ctrl0", rv, 32'h0);
      rd(ptm_pkg::ADDR_CTRL1);
      check("ctrl1", rv, 32'h0);
      check("pins", {out, outb, out_oe, outb_oe}, 4'b0100);
      wr10(ptm_pkg::ADDR_CMPA_H, 10'h25a);
      wr(ptm_pkg::ADDR_PER_L, 8'h11);
      rd10(ptm_pkg::ADDR_CMPA_H, v1);
      check("cmpa", v1, 10'h25a);
      wr(ptm_pkg::ADDR_PER_H, 8'h01);
      rd10(ptm_pkg::ADDR_PER_H, v1);
      check("shared buffer", v1, 10'h15a);
      wr10(ptm_pkg::ADDR_CNT_H, 10'h3ff);
      rd10(ptm_pkg::ADDR_CNT_H, v1);
      check("counter ro", v1, 10'h000);
      wr(12'h040, 8'h55);
      check("slverr", re, 1'b1);
      check("ready", pready, 1'b1);
      rd(12'h040);
      check("unmapped", rv, 32'h0);
      wr10(ptm_pkg::ADDR_PER_H, 10'h003);
      ext_run <= 1'b1;
      for (int s = 0; s < 8; s++) begin
         set_mode(8'h00);
         on(s[2:0]);
         gap(1'b1);
         check("tick period", n, 4 * dv[s]);
      end
      ext_run <= 1'b0;
      set_mode(8'h00);
      wr10(ptm_pkg::ADDR_PER_H, 10'h000);
      on(3'h1);
      gap(1'b1);
      check("overflow", n, 1024);
      set_mode(8'h01);
      wr10(ptm_pkg::ADDR_CMPA_H, 10'h005);
      on(3'h1);
      gap(1'b0);
      check("clear on a", n, 6);
      rd(ptm_pkg::ADDR_STATUS);
      check("flags", rv, 32'h3);
      wr(ptm_pkg::ADDR_STATUS, 8'h02);
      rd(ptm_pkg::ADDR_STATUS);
      check("flag clear", rv, 32'h1);
      wr(ptm_pkg::ADDR_PINSEL, 8'h03);
      @(negedge pclk);
      check("oe", {out_oe, outb_oe}, 2'b11);
      for (int f = 0; f < 4; f++) begin
         set_mode({2'b00, f[1:0], f != 2, 3'b001});
         on(3'h1);
         repeat (3) @(negedge pclk);
         check("initial level", out, f != 2);
         while (ev_a !== 1'b1) @(negedge pclk);
         repeat (2) @(negedge pclk);
         check("match action", {out, outb}, MEXP[f] ? 2'b10 : 2'b01);
      end
      set_mode(8'h00);
      on(3'h0);
      repeat (40) @(negedge pclk);
      wr(ptm_pkg::ADDR_CTRL0, 8'h88);
      rd10(ptm_pkg::ADDR_CNT_H, v1);
      repeat (40) @(negedge pclk);
      rd10(ptm_pkg::ADDR_CNT_H, v2);
      check("paused", v2, v1);
      wr(ptm_pkg::ADDR_CTRL0, 8'h08);
      repeat (40) @(negedge pclk);
      rd10(ptm_pkg::ADDR_CNT_H, v2);
      check("resumed", v2 > v1, 1'b1);
      wr(ptm_pkg::ADDR_CTRL0, 8'h00);
      rd10(ptm_pkg::ADDR_CNT_H, v1);
      repeat (40) @(negedge pclk);
      rd10(ptm_pkg::ADDR_CNT_H, v2);
      check("off holds", v2, v1);
      on(3'h0);
      rd10(ptm_pkg::ADDR_CNT_H, v1);
      check("on clears", v1 < 10'h004, 1'b1);
      for (int f = 0; f < 4; f++) begin
         set_mode({2'b01, f[1:0], 4'h0});
         wr10(ptm_pkg::ADDR_CMPA_H, 10'h3ff);
         // Paused, so a tick cannot match the captured value and add an event.
         wr(ptm_pkg::ADDR_CTRL0, 8'hb8);
         a_cnt = 0;
         u_pins.set_capture(1'b1);
         repeat (6) @(negedge pclk);
         check("capture rise", a_cnt, MEXP[f]);
         a_cnt = 0;
         u_pins.set_capture(1'b0);
         repeat (6) @(negedge pclk);
         check("capture fall", a_cnt, f == 1 || f == 2);
      end
      set_mode(8'h42);
      on(3'h1);
      repeat (50) @(negedge pclk);
      wr(ptm_pkg::ADDR_CTRL0, 8'h98);
      rd10(ptm_pkg::ADDR_CNT_H, v1);
      a_cnt = 0;
      u_pins.pulse_ext();
      repeat (8) @(negedge pclk);
      check("capture source", a_cnt, 1);
      rd10(ptm_pkg::ADDR_CMPA_H, v2);
      check("captured value", v2, v1);
      wr10(ptm_pkg::ADDR_CMPA_H, 10'h003);
      wr10(ptm_pkg::ADDR_PER_H, 10'h009);
      for (int i = 0; i < 3; i++) begin
         set_mode(pm[i]);
         on(3'h1);
         repeat (2) @(negedge pclk);
         check("forced level", out, pe[i]);
      end
      set_mode(8'ha8);
      on(3'h1);
      repeat (20) @(negedge pclk);
      hi = 0;
      repeat (100) begin
         @(negedge pclk);
         hi += (out === 1'b1);
      end
      check("pwm duty", hi >= 30 && hi <= 40, 1'b1);
      check("inverse", outb, 1'(~out));
      set_mode(8'hc0);
      wr(ptm_pkg::ADDR_PINSEL, 8'h00);
      on(3'h1);
      gap(1'b1);
      check("timer period", n, 10);
      check("pins off", {out_oe, outb_oe}, 2'b00);
      complete_run();
   end
endmodule // periodic_timer_module_tb_top
